// ### gp_defines.svh
// Constants for the port direction and data register block.
// Assumes inclusion by bare name from every file that decodes the map.
`ifndef GP_DEFINES_SVH
`define GP_DEFINES_SVH

// Register indices; byte address is four times the index
`define GP_IDX_LAT0   16'hff00
`define GP_IDX_LAT2   16'hff02
`define GP_IDX_LAT3   16'hff03
`define GP_IDX_LAT4   16'hff04
`define GP_IDX_LAT12  16'hff0c
`define GP_IDX_LAT13  16'hff0d
`define GP_IDX_DIR0   16'hff20
`define GP_IDX_DIR2   16'hff22
`define GP_IDX_DIR3   16'hff23
`define GP_IDX_DIR4   16'hff24
`define GP_IDX_DIR12  16'hff2c
`define GP_IDX_AMS    16'hff84
`define GP_IDX_ISTS   16'hffa0
`define GP_IDX_IMSK   16'hffa1

// Address fields
`define GP_IDX_MSB    17
`define GP_IDX_LSB    2
`define GP_BITW_POS   18
`define GP_MASK_MSB   15
`define GP_MASK_LSB   8

// Reset values and fills
`define GP_DIR_FILL   1'b1
`define GP_LAT_FILL   1'b0
`define GP_AMS_RST    4'h0
`define GP_MSK_RST    3'h7
`define GP_ISTS_RST   3'h0
`define GP_BYTE_ALL   8'hff

// Field positions
`define GP_RSTPIN_POS 4
`define GP_EV_P30     0
`define GP_EV_P31     1
`define GP_EV_P43     2
`define GP_P43_POS    3
`define GP_NEV        3

`endif

// ### gp_pkg.sv
// Types shared by the port register block.
// Assumes nothing beyond a SystemVerilog compiler.
package gp_pkg;

    // One bit per bidirectional pin, grouped by port
    typedef struct packed {
        logic [3:0] port12;
        logic [7:0] port4;
        logic [3:0] port3;
        logic [3:0] port2;
        logic [3:0] port0;
    } gp_pins_t;

    // Captured bus address phase
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic        bitw;
        logic [15:0] idx;
    } gp_aph_t;

endpackage

// ### gp_sync.sv
// Two-stage synchroniser for asynchronous pad inputs.
// Assumes one clock; first stage is read only by the second.
`timescale 1ns/1ps
`default_nettype none

module gp_sync #(
    parameter int W = 25
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    if (W < 1)
    begin : g_chk
        $error("gp_sync: width must be at least one");
    end

    for (genvar i = 0; i < W; i++)
    begin : g_bit
        logic s1_reg;
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                s1_reg <= 1'b0;
                q[i]   <= 1'b0;
            end
            else
            begin
                s1_reg <= d[i];
                q[i]   <= s1_reg;
            end
        end
    end

endmodule // gp_sync

`default_nettype wire

// ### gp_port.sv
// Port direction, output latch, analog select and pin-event interrupt block.
// Assumes an AHB-Lite master on hclk and asynchronous pads on pad_in.
`timescale 1ns/1ps
`default_nettype none
`include "gp_defines.svh"

module gp_port
    import gp_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output var  logic              hreadyout,
    output var  logic              hresp,
    output var  logic [31:0]       hrdata,
    input  wire gp_pins_t          pad_in,
    input  wire logic              reset_shared_input_pin,
    output var  gp_pins_t          pad_out,
    output var  gp_pins_t          pad_oe,
    output var  logic              p130_out,
    output var  logic [3:0]        analog_mode_select,
    output var  logic              irq
);

    if (ADDR_W <= `GP_BITW_POS)
    begin : g_chk
        $error("gp_port: address too narrow for the register map");
    end

    // Pad inputs cross into hclk
    gp_pins_t             pin_s;
    logic                 rst_pin_s;

    // Reset-shared pad rides the same synchroniser as the port pins
    gp_sync #(
        .W ($bits(gp_pins_t) + 1)
    ) u_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({reset_shared_input_pin, pad_in}),
        .q     ({rst_pin_s, pin_s})
    );

    // State
    gp_aph_t              aph_reg;
    gp_pins_t             lat_reg;
    gp_pins_t             lat_next;
    gp_pins_t             dir_reg;
    gp_pins_t             dir_next;
    gp_pins_t             oe_next;
    logic                 lat13_reg;
    logic                 lat13_next;
    logic [3:0]           ams_reg;
    logic [3:0]           ams_next;
    logic [`GP_NEV-1:0]   ists_reg;
    logic [`GP_NEV-1:0]   ists_next;
    logic [`GP_NEV-1:0]   imsk_reg;
    logic [`GP_NEV-1:0]   imsk_next;
    logic [`GP_NEV-1:0]   ev;

    // Address phase decode
    wire                  acc   = hsel & htrans[1] & hready;
    wire [15:0]           a_idx = haddr[`GP_IDX_MSB:`GP_IDX_LSB];
    wire                  rd_acc = acc & ~hwrite;

    // Data phase write strobes
    wire                  wr    = aph_reg.sel & aph_reg.wr;
    wire [15:0]           w_idx = aph_reg.idx;
    wire [7:0]            wv    = hwdata[7:0];
    wire [7:0]            bm    = aph_reg.bitw ? hwdata[`GP_MASK_MSB:`GP_MASK_LSB]
                                               : `GP_BYTE_ALL;

    wire                  w_lat0  = wr & (w_idx == `GP_IDX_LAT0);
    wire                  w_lat2  = wr & (w_idx == `GP_IDX_LAT2);
    wire                  w_lat3  = wr & (w_idx == `GP_IDX_LAT3);
    wire                  w_lat4  = wr & (w_idx == `GP_IDX_LAT4);
    wire                  w_lat12 = wr & (w_idx == `GP_IDX_LAT12);
    wire                  w_lat13 = wr & (w_idx == `GP_IDX_LAT13);
    wire                  w_dir0  = wr & (w_idx == `GP_IDX_DIR0);
    wire                  w_dir2  = wr & (w_idx == `GP_IDX_DIR2);
    wire                  w_dir3  = wr & (w_idx == `GP_IDX_DIR3);
    wire                  w_dir4  = wr & (w_idx == `GP_IDX_DIR4);
    wire                  w_dir12 = wr & (w_idx == `GP_IDX_DIR12);
    wire                  w_ams   = wr & (w_idx == `GP_IDX_AMS);
    wire                  w_ists  = wr & (w_idx == `GP_IDX_ISTS);
    wire                  w_imsk  = wr & (w_idx == `GP_IDX_IMSK);

    // Bits under the mask take the new value, others keep the old one
    function automatic logic [7:0] mrg(input logic [7:0] old);
        mrg = (old & ~bm) | (wv & bm);
    endfunction

    wire [7:0]            m_dir0  = mrg({4'h0, dir_reg.port0});
    wire [7:0]            m_dir2  = mrg({4'h0, dir_reg.port2});
    wire [7:0]            m_dir3  = mrg({4'h0, dir_reg.port3});
    wire [7:0]            m_dir4  = mrg(dir_reg.port4);
    wire [7:0]            m_dir12 = mrg({4'h0, dir_reg.port12});
    // same merge for every data latch
    wire [7:0]            m_lat0  = mrg({4'h0, lat_reg.port0});
    wire [7:0]            m_lat2  = mrg({4'h0, lat_reg.port2});
    wire [7:0]            m_lat3  = mrg({4'h0, lat_reg.port3});
    wire [7:0]            m_lat4  = mrg(lat_reg.port4);
    wire [7:0]            m_lat12 = mrg({4'h0, lat_reg.port12});
    wire [7:0]            m_lat13 = mrg({7'h0, lat13_reg});
    wire [7:0]            m_ams   = mrg({4'h0, ams_reg});
    wire [7:0]            m_imsk  = mrg({5'h0, imsk_reg});
    wire [7:0]            clr_b   = wv & bm;

    // one independent bit per pin; upper bits are never stored
    assign dir_next.port0  = w_dir0  ? m_dir0[3:0]  : dir_reg.port0;
    assign dir_next.port2  = w_dir2  ? m_dir2[3:0]  : dir_reg.port2;
    assign dir_next.port3  = w_dir3  ? m_dir3[3:0]  : dir_reg.port3;
    assign dir_next.port4  = w_dir4  ? m_dir4       : dir_reg.port4;
    assign dir_next.port12 = w_dir12 ? m_dir12[3:0] : dir_reg.port12;

    // output latches; port 3 holds no latch for the reset pin
    assign lat_next.port0  = w_lat0  ? m_lat0[3:0]  : lat_reg.port0;
    assign lat_next.port2  = w_lat2  ? m_lat2[3:0]  : lat_reg.port2;
    assign lat_next.port3  = w_lat3  ? m_lat3[3:0]  : lat_reg.port3;
    assign lat_next.port4  = w_lat4  ? m_lat4       : lat_reg.port4;
    assign lat_next.port12 = w_lat12 ? m_lat12[3:0] : lat_reg.port12;
    assign lat13_next   = w_lat13 ? m_lat13[0]   : lat13_reg;

    // analog select, one per port 2 pin
    assign ams_next     = w_ams   ? m_ams[3:0]   : ams_reg;
    assign imsk_next    = w_imsk  ? m_imsk[`GP_NEV-1:0] : imsk_reg;

    // buffer on for direction zero; converter mode keeps it off
    assign oe_next      = ~dir_next;
    wire [3:0]            oe2_next = oe_next.port2 & ~ams_next;

    // latch change on an output-mode interrupt-shared pin
    assign ev[`GP_EV_P30] = oe_next.port3[0] & (lat_next.port3[0] ^ lat_reg.port3[0]);
    assign ev[`GP_EV_P31] = oe_next.port3[1] & (lat_next.port3[1] ^ lat_reg.port3[1]);
    assign ev[`GP_EV_P43] = oe_next.port4[`GP_P43_POS]
                          & (lat_next.port4[`GP_P43_POS] ^ lat_reg.port4[`GP_P43_POS]);

    // Set wins over a write-one clear in the same cycle
    wire [`GP_NEV-1:0]    ists_clr = w_ists ? clr_b[`GP_NEV-1:0] : `GP_ISTS_RST;
    assign ists_next    = (ists_reg & ~ists_clr) | ev;

    // pin level for inputs, latch for outputs
    wire gp_pins_t        rd_pins = (dir_next & pin_s) | (~dir_next & lat_next);
    // Converter-mode pins read low on the digital path
    wire [3:0]            rd_port2 = rd_pins.port2 & ~ams_next;
    // reset-shared bit reads its pad only
    wire [7:0]            rd_port3 = {3'h0, rst_pin_s, rd_pins.port3};
    wire [3:0]            dfill   = {4{`GP_DIR_FILL}};

    // register decode for reads; missing bits read zero, except the upper direction bits, which read one
    wire [7:0]            rd_byte =
        (a_idx == `GP_IDX_LAT0)  ? {4'h0, rd_pins.port0}    :
        (a_idx == `GP_IDX_LAT2)  ? {4'h0, rd_port2}         :
        (a_idx == `GP_IDX_LAT3)  ? rd_port3                 :
        (a_idx == `GP_IDX_LAT4)  ? rd_pins.port4            :
        (a_idx == `GP_IDX_LAT12) ? {4'h0, rd_pins.port12}   :
        (a_idx == `GP_IDX_LAT13) ? {7'h0, lat13_next}       :
        (a_idx == `GP_IDX_DIR0)  ? {dfill, dir_next.port0}  :
        (a_idx == `GP_IDX_DIR2)  ? {dfill, dir_next.port2}  :
        (a_idx == `GP_IDX_DIR3)  ? {dfill, dir_next.port3}  :
        (a_idx == `GP_IDX_DIR4)  ? dir_next.port4           :
        (a_idx == `GP_IDX_DIR12) ? {dfill, dir_next.port12} :
        (a_idx == `GP_IDX_AMS)   ? {4'h0, ams_next}         :
        (a_idx == `GP_IDX_ISTS)  ? {5'h0, ists_next}        :
        (a_idx == `GP_IDX_IMSK)  ? {5'h0, imsk_next}        :
                                   8'h00;

    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            aph_reg   <= '0;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            aph_reg   <= '{sel: acc, wr: hwrite, bitw: haddr[`GP_BITW_POS], idx: a_idx};
            hrdata    <= rd_acc ? {24'h0, rd_byte} : 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // reset state; writes land at the data-phase edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dir_reg   <= {$bits(gp_pins_t){`GP_DIR_FILL}};
            lat_reg   <= {$bits(gp_pins_t){`GP_LAT_FILL}};
            lat13_reg <= `GP_LAT_FILL;
            ams_reg   <= `GP_AMS_RST;
            imsk_reg  <= `GP_MSK_RST;
        end
        else
        begin
            dir_reg   <= dir_next;
            lat_reg   <= lat_next;
            lat13_reg <= lat13_next;
            ams_reg   <= ams_next;
            imsk_reg  <= imsk_next;
        end
    end

    // Pin drivers register the same next values, so outputs come from flops
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pad_out            <= {$bits(gp_pins_t){`GP_LAT_FILL}};
            pad_oe             <= {$bits(gp_pins_t){1'b0}};
            p130_out           <= `GP_LAT_FILL;
            analog_mode_select <= `GP_AMS_RST;
        end
        else
        begin
            pad_out            <= lat_next;
            pad_oe             <= '{port12: oe_next.port12, port4: oe_next.port4,
                                    port3: oe_next.port3, port2: oe2_next,
                                    port0: oe_next.port0};
            p130_out           <= lat13_next;
            analog_mode_select <= ams_next;
        end
    end

    // Sticky events and the gated interrupt line
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ists_reg <= `GP_ISTS_RST;
            irq      <= 1'b0;
        end
        else
        begin
            ists_reg <= ists_next;
            irq      <= |(ists_next & ~imsk_next);
        end
    end

    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    wire wr_dir4 = w_dir4 & ~aph_reg.bitw;
    wire wr_lat4 = w_lat4 & ~aph_reg.bitw;

    // No reset edge at time zero, so registers are judged one tick later
    a_reset_state: assert property (disable iff (1'b0)
        !hresetn |=> (dir_reg == {$bits(gp_pins_t){`GP_DIR_FILL}})
                  && (lat_reg == {$bits(gp_pins_t){`GP_LAT_FILL}}) && !lat13_reg)
        else $error("reset state of direction or latch wrong");

    a_oe_from_dir: assert property (wr_dir4 |=> pad_oe.port4 == ~$past(wv))
        else $error("output enable does not follow direction write");

    a_latch_drives: assert property (wr_lat4 |=> pad_out.port4 == $past(wv))
        else $error("latch write did not reach pad");

    a_p130_drive: assert property (
        (w_lat13 && !aph_reg.bitw) |=> p130_out == $past(wv[0]))
        else $error("output-only latch did not reach pin");

    a_bit_write: assert property (
        (w_dir4 && aph_reg.bitw)
        |=> ((dir_reg.port4 ^ $past(dir_reg.port4)) & ~$past(bm)) == 8'h00)
        else $error("single-bit write touched other direction bits");

    a_read_mix: assert property (
        (rd_acc && a_idx == `GP_IDX_LAT4 && !wr) |=>
        hrdata[7:0] == (($past(dir_reg.port4) & $past(pin_s.port4))
                      | (~$past(dir_reg.port4) & $past(lat_reg.port4))))
        else $error("port read mixes pin and latch wrongly");

    a_upper_zero: assert property (
        (rd_acc && a_idx == `GP_IDX_LAT0) |=> hrdata[31:4] == 28'h0)
        else $error("unimplemented data bits not zero");

    a_dir_fill: assert property (
        (rd_acc && a_idx == `GP_IDX_DIR12) |=> hrdata[7:4] == 4'hf)
        else $error("upper direction bits not one");

    a_reset_pin_ro: assert property (
        (rd_acc && a_idx == `GP_IDX_LAT3) |=> hrdata[`GP_RSTPIN_POS] == $past(rst_pin_s))
        else $error("reset-shared bit not read from pad");

    a_event_flag: assert property (
        (ev[`GP_EV_P43] && pad_oe.port4[`GP_P43_POS]) |=> ists_reg[`GP_EV_P43])
        else $error("pin change did not set interrupt flag");

    a_status_clear: assert property (
        (w_ists && clr_b[`GP_EV_P30] && !ev[`GP_EV_P30]) |=> !ists_reg[`GP_EV_P30])
        else $error("write-one clear left status bit set");

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave inserted a wait or an error");

    a_irq_level: assert property (
        (ists_reg[`GP_EV_P30] && !imsk_reg[`GP_EV_P30] && !w_ists && !w_imsk)
        |=> irq)
        else $error("unmasked flag did not raise interrupt");

    a_analog_off: assert property (
        ams_reg[0] |-> !pad_oe.port2[0] && analog_mode_select[0])
        else $error("converter-mode pin still driven");

    c_dir_write: cover property (wr_dir4 ##1 pad_oe.port4 != 8'h00);
    c_analog_sel: cover property (w_ams ##1 analog_mode_select != 4'h0);
    c_bit_write: cover property (w_lat4 && aph_reg.bitw);
    c_irq_rise:  cover property (!irq ##1 irq);
    c_w1c_clear: cover property (w_ists && ists_reg != `GP_ISTS_RST);

endmodule // gp_port

`default_nettype wire

// ### gp_pad_model.sv
// Model of the external devices wired to the port pins.
// Assumes pad_oe high while the block drives a pin; no pull resistors.
`timescale 1ns/1ps
`default_nettype none
module gp_pad_model
    import gp_pkg::*;
(
    input  wire gp_pins_t pad_out,
    input  wire gp_pins_t pad_oe,
    input  wire gp_pins_t ext_drive,
    input  wire logic     ext_reset_pin,
    output var  gp_pins_t pad_in,
    output var  logic     reset_shared_input_pin
);
    // Block wins where it drives; the device drives every other pin
    always_comb
    begin
        pad_in = (pad_out & pad_oe) | (ext_drive & ~pad_oe);
        reset_shared_input_pin = ext_reset_pin;
    end
endmodule // gp_pad_model
`default_nettype wire

// ### port_direction_and_data_regs_tb.sv
// Self-checking bench for the port register block over AHB-Lite.
// Assumes gp_port, gp_pad_model and the shared defines header.
`timescale 1ns/1ps
`default_nettype none
`include "gp_defines.svh"
module port_direction_and_data_regs_tb;
    import gp_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
    gp_pins_t    pad_in;
    gp_pins_t    pad_out;
    gp_pins_t    pad_oe;
    // Device levels: port12=5, port4=c3, port3=a, port2=6, port0=9
    gp_pins_t    ext_drive = 24'h5c3a69;
    logic        ext_reset_pin = 1'b1;
    logic        reset_shared_input_pin;
    logic        p130_out;
    logic [3:0]  analog_mode_select;
    logic        irq;
    int          fail_count = 0;
    int          comparisons = 0;

    always #2 hclk = ~hclk;

    gp_port DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .pad_in(pad_in), .reset_shared_input_pin(reset_shared_input_pin),
        .pad_out(pad_out), .pad_oe(pad_oe),
        .p130_out(p130_out), .analog_mode_select(analog_mode_select), .irq(irq));

    gp_pad_model devs (.pad_out(pad_out), .pad_oe(pad_oe), .ext_drive(ext_drive),
        .ext_reset_pin(ext_reset_pin), .pad_in(pad_in),
        .reset_shared_input_pin(reset_shared_input_pin));

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    // Byte address is the register index times four; bit 18 is the masked alias
    task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic bw = 1'b0);
        logic [31:0] unused;
        bus(1'b1, {13'h0, bw, idx, 2'b00}, {16'h0, d}, unused);
    endtask

    task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_pin(input string nm, input logic [23:0] e, input logic [23:0] g);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rd_chk(input string nm, input logic [15:0] idx, input logic [7:0] e);
        logic [31:0] got;
        bus(1'b0, {14'h0, idx, 2'b00}, 32'h0, got);
        cmp_reg(nm, {24'h0, e}, got);
    endtask

    task automatic t_reset;
        @(negedge hclk);
        cmp_pin("oe", 24'h0, pad_oe);
        cmp_pin("out", 24'h0, pad_out);
        cmp_pin("misc", 24'h0, {18'h0, p130_out, analog_mode_select, irq});
        rd_chk("dir0", `GP_IDX_DIR0, 8'hff);
        rd_chk("dir2", `GP_IDX_DIR2, 8'hff);
        rd_chk("dir3", `GP_IDX_DIR3, 8'hff);
        rd_chk("dir4", `GP_IDX_DIR4, 8'hff);
        rd_chk("dir12", `GP_IDX_DIR12, 8'hff);
        rd_chk("lat0", `GP_IDX_LAT0, 8'h09);
        rd_chk("lat3", `GP_IDX_LAT3, 8'h1a);
        rd_chk("lat13", `GP_IDX_LAT13, 8'h00);
    endtask

    task automatic t_dir;
        wr(`GP_IDX_DIR4, 16'h005a);
        #1;
        cmp_pin("oe4", 24'ha5, {16'h0, pad_oe.port4});
        wr(`GP_IDX_DIR0, 16'h0000);
        wr(`GP_IDX_DIR12, 16'h000a);
        @(negedge hclk);
        cmp_pin("oe0", 24'hf, {20'h0, pad_oe.port0});
        cmp_pin("oe12", 24'h5, {20'h0, pad_oe.port12});
        rd_chk("dir4", `GP_IDX_DIR4, 8'h5a);
        rd_chk("dir0", `GP_IDX_DIR0, 8'hf0);
        rd_chk("dir12", `GP_IDX_DIR12, 8'hfa);
    endtask

    task automatic t_data;
        wr(`GP_IDX_LAT4, 16'h003c);
        #1;
        cmp_pin("out4", 24'h3c, {16'h0, pad_out.port4});
        rd_chk("lat4", `GP_IDX_LAT4, 8'h66);
        wr(`GP_IDX_LAT0, 16'h00ff);
        rd_chk("lat0", `GP_IDX_LAT0, 8'h0f);
        wr(`GP_IDX_LAT12, 16'h00ff);
        @(negedge hclk);
        cmp_pin("out12", 24'hf, {20'h0, pad_out.port12});
        cmp_pin("hresp", 24'h0, {23'h0, hresp});
    endtask

    task automatic t_bitw;
        wr(`GP_IDX_DIR4, 16'h0101, 1'b1);
        wr(`GP_IDX_LAT4, 16'h0400, 1'b1);
        @(negedge hclk);
        cmp_pin("oe4", 24'ha4, {16'h0, pad_oe.port4});
        cmp_pin("out4", 24'h38, {16'h0, pad_out.port4});
    endtask

    task automatic t_irq;
        wr(`GP_IDX_IMSK, 16'h0007);
        wr(`GP_IDX_DIR3, 16'h000c);
        wr(`GP_IDX_LAT3, 16'h0001);
        #1;
        cmp_pin("irq_masked", 24'h0, {23'h0, irq});
        rd_chk("status", `GP_IDX_ISTS, 8'h01);
        wr(`GP_IDX_IMSK, 16'h0006);
        @(negedge hclk);
        cmp_pin("irq_on", 24'h1, {23'h0, irq});
        wr(`GP_IDX_ISTS, 16'h0001);
        // Input-mode bit changes must not raise an event
        wr(`GP_IDX_LAT3, 16'h0005);
        @(negedge hclk);
        cmp_pin("irq_off", 24'h0, {23'h0, irq});
        rd_chk("status", `GP_IDX_ISTS, 8'h00);
        wr(`GP_IDX_DIR4, 16'h0800, 1'b1);
        wr(`GP_IDX_LAT4, 16'h0800, 1'b1);
        rd_chk("status43", `GP_IDX_ISTS, 8'h04);
        wr(`GP_IDX_ISTS, 16'h0004);
    endtask

    task automatic t_misc;
        // Converter bits keep the driver off whatever the direction says
        wr(`GP_IDX_AMS, 16'h0003);
        wr(`GP_IDX_DIR2, 16'h0000);
        wr(`GP_IDX_LAT2, 16'h000f);
        @(negedge hclk);
        cmp_pin("ams", 24'h3, {20'h0, analog_mode_select});
        cmp_pin("oe2", 24'hc, {20'h0, pad_oe.port2});
        rd_chk("lat2", `GP_IDX_LAT2, 8'h0c);
        // Converter pins set up as the alternate function wants: input mode
        wr(`GP_IDX_DIR2, 16'h000f);
        @(negedge hclk);
        cmp_pin("oe2_ana", 24'h0, {20'h0, pad_oe.port2});
        wr(`GP_IDX_LAT3, 16'h0015);
        @(posedge hclk);
        ext_reset_pin <= 1'b0;
        repeat (3) @(posedge hclk);
        rd_chk("lat3", `GP_IDX_LAT3, 8'h09);
        wr(`GP_IDX_LAT13, 16'h0001);
        #1;
        cmp_pin("p130", 24'h1, {23'h0, p130_out});
        rd_chk("lat13", `GP_IDX_LAT13, 8'h01);
        wr(16'hff10, 16'h00ff);
        rd_chk("unmapped", 16'hff10, 8'h00);
    endtask

    task automatic complete_run;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_dir();
        t_data();
        t_bitw();
        t_irq();
        t_misc();
        complete_run();
    end

    // Whole run needs well under 1000 cycles
    initial
    begin
        #20000;
        fail_count++;
        complete_run();
    end
endmodule // port_direction_and_data_regs_tb
`default_nettype wire
